// *** logic/adsc_defines.svh ***
// constants for the converter sequencer: offsets, fields, resets, timing
// assumes inclusion by bare name from logic/ files
`ifndef ADSC_DEFINES_SVH
`define ADSC_DEFINES_SVH
`define ADSC_OFF_PORT     12'h00c
`define ADSC_OFF_RESULT   12'h020
`define ADSC_OFF_STATCTL  12'h024
`define ADSC_OFF_IRQ_STAT 12'h040
`define ADSC_OFF_IRQ_MASK 12'h044
`define ADSC_BIT_DONE     7
`define ADSC_BIT_RCSEL    6
`define ADSC_BIT_ENABLE   5
`define ADSC_WR_MASK      8'h6f
`define ADSC_RESULT_RST   8'h00
`define ADSC_STATCTL_RST  8'h00
`define ADSC_SAMPLE_CYC   4'hc
`define ADSC_RC_DIV       4'h3
`define ADSC_CH_REFHI     4'h8
`define ADSC_CH_REFMID    4'h9
`endif

// *** logic/adsc_pkg.sv ***
// types for the converter sequencer
// assumes the defines header sits beside it
package adsc_pkg;
   typedef enum logic [1:0]
   {
      ADSC_IDLE   = 2'b00,
      ADSC_SAMPLE = 2'b01,
      ADSC_CONV   = 2'b10
   } adsc_state_t;
   typedef enum logic [1:0]
   {
      ADSC_SRC_PIN = 2'b00,
      ADSC_SRC_HI  = 2'b01,
      ADSC_SRC_MID = 2'b10,
      ADSC_SRC_LO  = 2'b11
   } adsc_src_t;
endpackage

// *** logic/adsc_tick.sv ***
// conversion step tick: bus clock, or divided pulse standing for the rc oscillator
// assumes one clock; the rc oscillator is modelled by a divider enable
`timescale 1ns/1ps
`default_nettype none
`include "adsc_defines.svh"
module adsc_tick
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic osc_on,
   input  wire logic use_osc,
   output logic      tick
);
   logic [3:0] div_reg;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         div_reg <= 4'h0;
      else if (!osc_on)
         div_reg <= 4'h0;
      else if (div_reg == `ADSC_RC_DIV)
         div_reg <= 4'h0;
      else
         div_reg <= div_reg + 4'h1;
   end
   assign tick = use_osc ? (osc_on && div_reg == `ADSC_RC_DIV) : 1'b1;
endmodule
`default_nettype wire

// *** logic/adsc_mux.sv ***
// selector decode: picks source from channel code
// assumes analog side performs the actual switching
`timescale 1ns/1ps
`default_nettype none
`include "adsc_defines.svh"
module adsc_mux
(
   input  wire logic [3:0] channel_select,
   output adsc_pkg::adsc_src_t src,
   output logic [2:0]      pin_index
);
   always_comb
   begin
      pin_index = channel_select[2:0];
      if (!channel_select[3])
         src = adsc_pkg::ADSC_SRC_PIN;
      else if (channel_select == `ADSC_CH_REFHI)
         src = adsc_pkg::ADSC_SRC_HI;
      else if (channel_select == `ADSC_CH_REFMID)
         src = adsc_pkg::ADSC_SRC_MID;
      else
         src = adsc_pkg::ADSC_SRC_LO;
   end
endmodule
`default_nettype wire

// *** logic/adsc_top.sv ***
// converter sequencer: apb registers, sample/approximate sequencing, interrupt
// assumes analog front end answers cmp_above one cycle-stable per trial code
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "adsc_defines.svh"
module adsc_top
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  shared_input_pins,
   input  wire logic        stop_mode,
   input  wire logic        wait_mode,
   input  wire logic        cmp_above,
   output logic      [7:0]  dac_code,
   output logic             sample_switch,
   output logic      [2:0]  pin_index,
   output adsc_pkg::adsc_src_t src,
   output logic             converter_on,
   output logic             rc_osc_on,
   output logic             irq
);
   adsc_pkg::adsc_state_t state_reg;
   logic [7:0] statctl_reg;
   logic [7:0] result_reg;
   logic [7:0] sar_reg;
   logic [3:0] cnt_reg;
   logic [1:0] irq_stat_reg;
   logic [1:0] irq_mask_reg;
   logic       access;
   logic       wr_ctl;
   logic       rd_res;
   logic       tick;
   logic       done;
   logic [7:0] trial;
   logic       converter_enable;
   logic       rc_osc_select;
   logic       conversion_done_flag;
   logic [3:0] channel_select;

   assign converter_enable     = statctl_reg[`ADSC_BIT_ENABLE];
   assign rc_osc_select        = statctl_reg[`ADSC_BIT_RCSEL];
   assign conversion_done_flag = statctl_reg[`ADSC_BIT_DONE];
   assign channel_select       = statctl_reg[3:0];

   assign access = psel && penable;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign wr_ctl = access && pwrite && paddr == `ADSC_OFF_STATCTL;
   assign rd_res = access && !pwrite && paddr == `ADSC_OFF_RESULT;

   // stop halts the converter and the rc oscillator; wait has no effect on the converter
   assign converter_on = converter_enable && !stop_mode;
   assign rc_osc_on    = rc_osc_select && !stop_mode;

   adsc_tick u_tick
   (
      .pclk    (pclk),
      .presetn (presetn),
      .osc_on  (rc_osc_on),
      .use_osc (rc_osc_select),
      .tick    (tick)
   );

   adsc_mux u_mux
   (
      .channel_select (channel_select),
      .src            (src),
      .pin_index      (pin_index)
   );

   assign trial = sar_reg | (8'h80 >> cnt_reg[2:0]);
   // a control write in the same cycle aborts this conversion, so it never completes
   assign done  = converter_on && !wr_ctl && state_reg == adsc_pkg::ADSC_CONV && tick
                  && cnt_reg == 4'h7;

   // sequencer; a control write restarts from sampling
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= adsc_pkg::ADSC_IDLE;
         cnt_reg   <= 4'h0;
         sar_reg   <= 8'h00;
      end
      else if (!converter_on)
      begin
         state_reg <= adsc_pkg::ADSC_IDLE;
         cnt_reg   <= 4'h0;
      end
      else if (wr_ctl)
      begin
         state_reg <= adsc_pkg::ADSC_SAMPLE;
         cnt_reg   <= 4'h0;
         sar_reg   <= 8'h00;
      end
      else
      begin
         case (state_reg)
            adsc_pkg::ADSC_IDLE:
            begin
               state_reg <= adsc_pkg::ADSC_SAMPLE;
               cnt_reg   <= 4'h0;
               sar_reg   <= 8'h00;
            end
            adsc_pkg::ADSC_SAMPLE:
            begin
               // sampling counts bus cycles, not converter ticks
               if (cnt_reg == `ADSC_SAMPLE_CYC - 4'h1)
               begin
                  state_reg <= adsc_pkg::ADSC_CONV;
                  cnt_reg   <= 4'h0;
               end
               else
                  cnt_reg <= cnt_reg + 4'h1;
            end
            adsc_pkg::ADSC_CONV:
            begin
               if (tick)
               begin
                  if (cnt_reg == 4'h7)
                  begin
                     // result leaves through result_reg; the restart begins from zero
                     state_reg <= adsc_pkg::ADSC_SAMPLE;
                     cnt_reg   <= 4'h0;
                     sar_reg   <= 8'h00;
                  end
                  else
                  begin
                     sar_reg <= cmp_above ? trial : sar_reg;
                     cnt_reg <= cnt_reg + 4'h1;
                  end
               end
            end
            default:
               state_reg <= adsc_pkg::ADSC_IDLE;
         endcase
      end
   end

   assign sample_switch = state_reg == adsc_pkg::ADSC_SAMPLE;
   assign dac_code = (state_reg == adsc_pkg::ADSC_CONV) ? trial : sar_reg;

   // closed-switch run length for the sampling checks; a restart write begins a new run
   logic [4:0] samp_run_reg;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         samp_run_reg <= 5'h00;
      else if (sample_switch && !wr_ctl)
         samp_run_reg <= samp_run_reg + 5'h01;
      else
         samp_run_reg <= 5'h00;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         result_reg <= `ADSC_RESULT_RST;
      else if (done)
         result_reg <= cmp_above ? trial : sar_reg;
   end

   // control bits; done flag set wins over read clear, write aborts so clears
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         statctl_reg <= `ADSC_STATCTL_RST;
      else if (wr_ctl)
         statctl_reg <= pwdata[7:0] & `ADSC_WR_MASK;
      else if (done)
         statctl_reg[`ADSC_BIT_DONE] <= 1'b1;
      else if (rd_res)
         statctl_reg[`ADSC_BIT_DONE] <= 1'b0;
   end

   // bit0 done event, bit1 abort-by-write event; write one clears
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_stat_reg <= 2'b00;
         irq_mask_reg <= 2'b00;
      end
      else
      begin
         irq_stat_reg <= (irq_stat_reg & ~((access && pwrite &&
                          paddr == `ADSC_OFF_IRQ_STAT) ? pwdata[1:0] : 2'b00))
                         | {wr_ctl && state_reg != adsc_pkg::ADSC_IDLE, done};
         if (access && pwrite && paddr == `ADSC_OFF_IRQ_MASK)
            irq_mask_reg <= pwdata[1:0];
      end
   end
   assign irq = |(irq_stat_reg & irq_mask_reg);

   // read data registered in the setup phase; pins sampled on every port read, any mode
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
      begin
         if (paddr == `ADSC_OFF_PORT)
            prdata <= {24'h000000, shared_input_pins};
         else if (paddr == `ADSC_OFF_RESULT)
            prdata <= {24'h000000, result_reg};
         else if (paddr == `ADSC_OFF_STATCTL)
            prdata <= {24'h000000, statctl_reg};
         else if (paddr == `ADSC_OFF_IRQ_STAT)
            prdata <= {30'h00000000, irq_stat_reg};
         else if (paddr == `ADSC_OFF_IRQ_MASK)
            prdata <= {30'h00000000, irq_mask_reg};
         else
            prdata <= 32'h0000_0000;
      end
   end

   logic unused_wait;
   assign unused_wait = wait_mode;

   // long windows are counted in helper logic rather than written as repetitions
   a_sample_len: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(sample_switch) && $past(converter_on) && !$past(wr_ctl) |->
      samp_run_reg == {1'b0, `ADSC_SAMPLE_CYC})
      else $error("sample window not 12 cycles");
   a_sample_max: assert property (@(posedge pclk) disable iff (!presetn)
      samp_run_reg <= {1'b0, `ADSC_SAMPLE_CYC})
      else $error("sample window too long");
   a_done_sets: assert property (@(posedge pclk) disable iff (!presetn)
      done && !wr_ctl |=> conversion_done_flag)
      else $error("done flag not set");
   a_read_clears: assert property (@(posedge pclk) disable iff (!presetn)
      rd_res && !done && !wr_ctl |=> !conversion_done_flag)
      else $error("result read did not clear flag");
   a_write_restart: assert property (@(posedge pclk) disable iff (!presetn)
      wr_ctl && converter_on && !stop_mode |=> state_reg == adsc_pkg::ADSC_SAMPLE
      && !conversion_done_flag) else $error("write did not restart");
   a_bit4_zero: assert property (@(posedge pclk) disable iff (!presetn)
      statctl_reg[4] == 1'b0) else $error("bit 4 set");
   a_off_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !converter_on |=> $stable(result_reg)) else $error("result moved while off");
   a_stop_off: assert property (@(posedge pclk) disable iff (!presetn)
      stop_mode |-> !converter_on && !rc_osc_on) else $error("active in stop");
   a_result_load: assert property (@(posedge pclk) disable iff (!presetn)
      done |=> result_reg == $past(dac_code) || result_reg == $past(sar_reg))
      else $error("result not loaded");
   a_osc_alone: assert property (@(posedge pclk) disable iff (!presetn)
      rc_osc_select && !converter_enable && !stop_mode
      |-> rc_osc_on && !converter_on)
      else $error("rc oscillator not running alone");
   a_port_read: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && paddr == `ADSC_OFF_PORT
      |=> prdata == {24'h000000, $past(shared_input_pins)})
      else $error("port read lost pin levels");
   a_off_no_done: assert property (@(posedge pclk) disable iff (!presetn)
      !converter_on |-> !done)
      else $error("completion while converter off");
   a_flag_from_done: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(conversion_done_flag) |-> $past(done))
      else $error("done flag set without completion");
   a_result_only_done: assert property (@(posedge pclk) disable iff (!presetn)
      !done |=> $stable(result_reg))
      else $error("result moved without completion");
   a_dac_msb: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == adsc_pkg::ADSC_CONV && cnt_reg == 4'h0
      |-> dac_code == 8'h80)
      else $error("first trial is not the top bit alone");
   a_abort_event: assert property (@(posedge pclk) disable iff (!presetn)
      wr_ctl && state_reg != adsc_pkg::ADSC_IDLE |=> irq_stat_reg[1])
      else $error("abort event not recorded");
   a_done_irq: assert property (@(posedge pclk) disable iff (!presetn)
      done |=> irq_stat_reg[0])
      else $error("completion event not recorded");
   a_stop_no_tick: assert property (@(posedge pclk) disable iff (!presetn)
      stop_mode && rc_osc_select |-> !tick)
      else $error("converter clocked during stop");

   c_done: cover property (@(posedge pclk) done);
   c_abort: cover property (@(posedge pclk) wr_ctl && state_reg == adsc_pkg::ADSC_CONV);
   c_rc: cover property (@(posedge pclk) done && rc_osc_select);
   c_auto_restart: cover property (@(posedge pclk) done ##1 sample_switch);
   c_osc_alone: cover property (@(posedge pclk) rc_osc_on && !converter_on);
endmodule
`default_nettype wire

// *** bench/adsc_front_model.sv ***
// analog front end: pin levels, references and the sample capacitor
// assumes the sequencer's selector decode, sample switch and trial code
`timescale 1ns/1ps
`default_nettype none
module adsc_front_model
(
   input  wire logic                pclk,
   input  wire logic [63:0]         pin_level,
   input  wire logic [2:0]          pin_index,
   input  wire adsc_pkg::adsc_src_t src,
   input  wire logic                sample_switch,
   input  wire logic [7:0]          dac_code,
   output logic                     cmp_above
);
   logic [7:0] held;
   logic [7:0] vin;
   always_comb
   begin
      case (src)
         adsc_pkg::ADSC_SRC_PIN: vin = pin_level[pin_index*8 +: 8];
         adsc_pkg::ADSC_SRC_HI:  vin = 8'hff;
         adsc_pkg::ADSC_SRC_MID: vin = 8'h80;
         default:                vin = 8'h00;
      endcase
   end
   // the capacitor follows only while the switch is closed, then holds
   always_ff @(posedge pclk)
      if (sample_switch)
         held <= vin;
   assign cmp_above = (held >= dac_code);
endmodule
`default_nettype wire

// *** bench/test_adc_sequencer_control.sv ***
// testbench for the converter sequencer: apb master, front-end model
// assumes zero-wait apb slave and register map of the defines header
`timescale 1ns/1ps
`default_nettype none
`include "adsc_defines.svh"
module test_adc_sequencer_control;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] shared_input_pins, dac_code;
   logic stop_mode, wait_mode, cmp_above, sample_switch;
   logic converter_on, rc_osc_on, irq;
   logic [2:0] pin_index;
   adsc_pkg::adsc_src_t src;
   logic [63:0] pin_level;
   int bad_count, checked, run_len, last_run;
   adsc_top adsc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .shared_input_pins(shared_input_pins), .stop_mode(stop_mode),
      .wait_mode(wait_mode), .cmp_above(cmp_above), .dac_code(dac_code),
      .sample_switch(sample_switch), .pin_index(pin_index), .src(src),
      .converter_on(converter_on), .rc_osc_on(rc_osc_on), .irq(irq));
   adsc_front_model adsc_front_model_i (.pclk(pclk), .pin_level(pin_level),
      .pin_index(pin_index), .src(src), .sample_switch(sample_switch),
      .dac_code(dac_code), .cmp_above(cmp_above));
   initial
   begin
      pclk = 0;
      forever #5 pclk = ~pclk;
   end
   // length of the latest closed-switch run, in bus cycles
   // a control write restarts sampling, so the run starts over there
   always @(posedge pclk)
      if (psel && penable && pwrite && paddr == `ADSC_OFF_STATCTL)
         run_len <= 0;
      else if (sample_switch === 1'b1)
         run_len <= run_len + 1;
      else if (run_len != 0)
      begin
         last_run <= run_len;
         run_len <= 0;
      end
   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      chk("pslverr", pslverr, 1'b0);
      psel <= 1'b0; penable <= 1'b0;
      // outputs launched at the access edge are looked at once settled
      @(negedge pclk);
   endtask
   // poll the status/control register until the done flag rises
   task wait_done();
      int n;
      n = 0;
      do begin apb(0, `ADSC_OFF_STATCTL, 0); n++; end while (rd[7] !== 1'b1 && n < 200);
      chk("done flag", rd[7], 1'b1);
   endtask
   task t_reset();
      apb(0, `ADSC_OFF_STATCTL, 0); chk("statctl reset", rd, 32'h0);
      apb(0, `ADSC_OFF_RESULT, 0); chk("result reset", rd, 32'h0);
      apb(1, `ADSC_OFF_STATCTL, 32'h10);
      apb(0, `ADSC_OFF_STATCTL, 0); chk("bit4", rd, 32'h0);
      chk("conv off", converter_on, 1'b0);
      apb(0, `ADSC_OFF_PORT, 0); chk("port off", rd, 32'ha5);
      apb(0, 12'h100, 0); chk("unmapped", rd, 32'h0);
      $display("test reset done");
   endtask
   task t_channels();
      logic [7:0] exp [0:10];
      exp = '{8'h11, 8'h22, 8'h5a, 8'h44, 8'h00, 8'hff, 8'h7f, 8'h80, 8'hff, 8'h80, 8'h00};
      for (int c = 0; c < 11; c++)
      begin
         apb(1, `ADSC_OFF_STATCTL, 32'h20 | c);
         wait_done();
         apb(0, `ADSC_OFF_RESULT, 0); chk("result", rd, {24'h0, exp[c]});
         apb(0, `ADSC_OFF_STATCTL, 0); chk("flag clear", rd, 32'h20 | c);
         chk("sample len", last_run, 12);
         wait_done();
         apb(0, `ADSC_OFF_RESULT, 0); chk("auto result", rd, {24'h0, exp[c]});
      end
      apb(0, `ADSC_OFF_PORT, 0); chk("port on", rd, 32'ha5);
      $display("test channels done");
   endtask
   task t_irq_modes();
      @(posedge pclk);
      wait_mode <= 1'b0;
      apb(1, `ADSC_OFF_IRQ_MASK, 32'h1);
      apb(1, `ADSC_OFF_STATCTL, 32'h62);
      chk("rc on", rc_osc_on, 1'b1);
      // earlier conversions left events behind; start from a clean status
      apb(1, `ADSC_OFF_IRQ_STAT, 32'h3); chk("irq low", irq, 1'b0);
      wait_done();
      chk("irq up", irq, 1'b1);
      apb(0, `ADSC_OFF_RESULT, 0); chk("rc result", rd, 32'h5a);
      apb(1, `ADSC_OFF_IRQ_MASK, 32'h0); chk("irq masked", irq, 1'b0);
      apb(1, `ADSC_OFF_STATCTL, 32'h40);
      chk("osc alone", {rc_osc_on, converter_on}, 2'b10);
      apb(0, `ADSC_OFF_IRQ_STAT, 0); chk("irq events", rd, 32'h3);
      apb(1, `ADSC_OFF_IRQ_STAT, 32'h3);
      apb(1, `ADSC_OFF_IRQ_MASK, 32'h1); chk("irq clear", irq, 1'b0);
      repeat (60) @(posedge pclk);
      apb(0, `ADSC_OFF_STATCTL, 0); chk("idle", rd, 32'h40);
      apb(0, `ADSC_OFF_RESULT, 0); chk("kept", rd, 32'h5a);
      apb(1, `ADSC_OFF_STATCTL, 32'h60);
      @(posedge pclk);
      stop_mode <= 1'b1;
      @(negedge pclk);
      chk("stop", {rc_osc_on, converter_on}, 2'b00);
      @(posedge pclk);
      stop_mode <= 1'b0;
      @(negedge pclk);
      chk("after stop", converter_on, 1'b1);
      $display("test irq and modes done");
   endtask
   task finish_test();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      #400000;
      bad_count++;
      finish_test();
   end
   initial
   begin
      bad_count = 0; checked = 0; run_len = 0; last_run = 0;
      presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      stop_mode = 0; wait_mode = 1; shared_input_pins = 8'ha5;
      pin_level = {8'h7f, 8'hff, 8'h00, 8'h44, 8'h5a, 8'h22, 8'h11, 8'h00};
      pin_level[7:0] = 8'h11; pin_level[15:8] = 8'h22; pin_level[31:24] = 8'h44;
      pin_level[39:32] = 8'h00; pin_level[47:40] = 8'hff; pin_level[55:48] = 8'h7f;
      pin_level[63:56] = 8'h80; pin_level[23:16] = 8'h5a;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      // wait mode stays high until the irq and modes test drops it: the converter must not notice it
      t_reset();
      t_channels();
      t_irq_modes();
      finish_test();
   end
endmodule
`default_nettype wire
